/* storage_pkg.sv */
// Package with the constants and types shared by the clocked storage block.
package storage_pkg;
    // Stage counts of the ripple counter, the flip-flop shift register and one-bit stages.
    localparam int CNT_STAGES = 4;
    localparam int SR_STAGES  = 4;
    localparam int BIT_STAGES = 2;
    localparam int LATCHED_IX = 0;  // Stage 0 has the latch-feedback phase.
    localparam int DYNAMIC_IX = 1;  // Stage 1 is the dynamic variant.

    // Timing, in printed units, and the derived cycle counts at 50 MHz.
    localparam int CLK_PERIOD_NS = 20;
    localparam int RETAIN_US     = 50;
    localparam int MIN_PHASE_NS  = 500;
    localparam int RETAIN_CYC    = (RETAIN_US * 1000) / CLK_PERIOD_NS;
    localparam int MIN_PHASE_CYC = (MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AGE_W         = 12;
    localparam logic [AGE_W-1:0] AGE_LAST  = AGE_W'(RETAIN_CYC - 1);
    localparam logic [AGE_W-1:0] AGE_ZERO  = 12'h000;
    localparam logic [AGE_W-1:0] AGE_ONE   = 12'h001;
    localparam logic [AGE_W-1:0] ON_MIN    = AGE_W'(MIN_PHASE_CYC);
    localparam logic [AGE_W-1:0] ON_SAT    = 12'hFFF;

    // Phase fault bit positions.
    localparam int FAULT_OVERLAP = 0;
    localparam int FAULT_SHORT   = 1;

    // Progress of a one-bit stage through its phases.
    typedef enum logic [3:0] {
        ST_EMPTY = 4'h1,
        ST_XFER  = 4'h2,
        ST_HOLD  = 4'h4,
        ST_LATCH = 4'h8
    } stage_e;
endpackage

/* ms_cell_if.sv */
// Interface joining one master-slave flip-flop cell to the logic around it.
`timescale 1ns/100ps
interface ms_cell_if;
    logic clk_lvl;
    logic set_in;
    logic reset_in;
    logic q;
    logic master;

    modport flop (input clk_lvl, input set_in, input reset_in, output q, output master);
    modport user (output clk_lvl, output set_in, output reset_in, input q, input master);
endinterface

/* ms_cell.sv */
// Master-slave flip-flop cell with set and reset inputs and a level clock.
`timescale 1ns/100ps
module ms_cell
    import storage_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Cell connection.
    ms_cell_if.flop  port
);
    typedef struct packed {
        logic prev_clk;
        logic master;
        logic slave;
    } cell_s;

    cell_s st_reg;
    cell_s st_next;

    // Master loads on the rising clock level, slave copies it on the falling level.
    always_comb begin
        st_next = st_reg;
        st_next.prev_clk = port.clk_lvl;
        if (port.clk_lvl && !st_reg.prev_clk) begin
            if (port.set_in) begin
                st_next.master = 1'b1;
            end else if (port.reset_in) begin
                st_next.master = 1'b0;
            end
        end
        if (!port.clk_lvl && st_reg.prev_clk) begin
            st_next.slave = st_reg.master;
        end
    end

    // State register.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs of the cell.
    assign port.q      = st_reg.slave;
    assign port.master = st_reg.master;

    chk_master_set_capture: assert property (@(posedge core_clk) disable iff (reset)
        ($rose(port.clk_lvl) && port.set_in) |=> port.master)
        else $error("Master did not set on rising clock.");

    chk_slave_follows: assert property (@(posedge core_clk) disable iff (reset)
        $fell(port.clk_lvl) |=> (port.q == $past(port.master)))
        else $error("Slave did not take master value on falling clock.");
endmodule

/* clocked_storage_elements.sv */
// Clock generator, ripple counter, shift register and one-bit phase-driven stages.
`timescale 1ns/100ps
// Behaviour
// - Counter stage toggles when previous falls.
// - Master loads on clock rise, slave follows.
// - Shift master takes data, passes onward.
// - Generated clock pair never equal.
// - Transfer admits data, output one delay later.
// - Latch phase holds output until next transfer.
// - Dynamic stage works without latch phase.
module clocked_storage_elements
    import storage_pkg::*;
(
    // Clock and reset.
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    // Square wave for the clock generator and shift register data.
    input  wire logic                  square_in,
    input  wire logic                  ser_in,
    // Generated clock pair.
    output logic                       gen_clk,
    output logic                       gen_clk_n,
    // Counter and shift register state.
    output logic [CNT_STAGES-1:0]      cnt_q,
    output logic [SR_STAGES-1:0]       sr_q,
    // Outside phases of the one-bit stages.
    input  wire logic                  xfer_ph,
    input  wire logic                  hold_ph,
    input  wire logic                  latch_ph,
    // One-bit stage data.
    input  wire logic [BIT_STAGES-1:0] bit_in,
    output logic [BIT_STAGES-1:0]      bit_out,
    output logic [BIT_STAGES-1:0]      bit_valid,
    output logic [1:0]                 phase_fault
);
    typedef struct packed {
        logic                              gen_clk;
        logic                              gen_clk_n;
        stage_e [BIT_STAGES-1:0]           mode;
        logic [BIT_STAGES-1:0]             input_storage_node;
        logic [BIT_STAGES-1:0]             output_storage_node;
        logic [BIT_STAGES-1:0]             stage_out;
        logic [BIT_STAGES-1:0]             valid;
        logic [BIT_STAGES-1:0][AGE_W-1:0]  age;
        logic                              xfer_prev;
        logic [AGE_W-1:0]                  on_cnt;
        logic [1:0]                        fault;
    } top_s;

    top_s st_reg;
    top_s st_next;

    logic [SR_STAGES-1:0] sr_master;

    ms_cell_if cnt_if [CNT_STAGES] ();
    ms_cell_if sr_if  [SR_STAGES] ();

    // Ripple counter: the first cell is clocked by the generated clock, each later cell by the slave of the one before it.
    for (genvar i = 0; i < CNT_STAGES; i++) begin : g_cnt
        if (i == 0) begin : g_first
            assign cnt_if[i].clk_lvl = st_reg.gen_clk;
        end else begin : g_rest
            assign cnt_if[i].clk_lvl = cnt_if[i-1].q;
        end
        assign cnt_if[i].set_in   = ~cnt_if[i].q;
        assign cnt_if[i].reset_in = cnt_if[i].q;
        assign cnt_q[i]           = cnt_if[i].q;
        ms_cell u_cell (
            .core_clk (core_clk),
            .reset    (reset),
            .port     (cnt_if[i])
        );
    end

    // Shift register: all cells share the generated clock, data walks one cell per period.
    for (genvar i = 0; i < SR_STAGES; i++) begin : g_sr
        if (i == 0) begin : g_first
            assign sr_if[i].set_in = ser_in;
        end else begin : g_rest
            assign sr_if[i].set_in = sr_if[i-1].q;
        end
        assign sr_if[i].clk_lvl  = st_reg.gen_clk;
        assign sr_if[i].reset_in = ~sr_if[i].set_in;
        assign sr_q[i]           = sr_if[i].q;
        assign sr_master[i]      = sr_if[i].master;
        ms_cell u_cell (
            .core_clk (core_clk),
            .reset    (reset),
            .port     (sr_if[i])
        );
    end

    // Generator pair, one-bit stage phase machines, retention ageing and phase faults.
    always_comb begin
        st_next = st_reg;
        st_next.gen_clk   = square_in;
        st_next.gen_clk_n = ~square_in;
        for (int k = 0; k < BIT_STAGES; k++) begin
            case (st_reg.mode[k])
                ST_EMPTY: begin
                    if (xfer_ph) begin
                        st_next.mode[k] = ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (!xfer_ph) begin
                        st_next.mode[k] = ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (xfer_ph) begin
                        st_next.mode[k] = ST_XFER;
                    end else if (latch_ph && k == LATCHED_IX) begin
                        st_next.mode[k] = ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    if (xfer_ph) begin
                        st_next.mode[k] = ST_XFER;
                    end
                end
                default: begin
                    st_next.mode[k] = ST_EMPTY;
                end
            endcase
            if (xfer_ph) begin
                st_next.input_storage_node[k] = bit_in[k];
                st_next.valid[k]   = 1'b1;
                st_next.age[k]     = AGE_ZERO;
            end else if (st_reg.mode[k] != ST_LATCH && st_reg.valid[k]) begin
                // Unlatched charge leaks away after the retention time.
                if (st_reg.age[k] == AGE_LAST) begin
                    st_next.valid[k] = 1'b0;
                end else begin
                    st_next.age[k] = st_reg.age[k] + AGE_ONE;
                end
            end
            if (!xfer_ph && (hold_ph || st_reg.mode[k] == ST_LATCH)) begin
                st_next.output_storage_node[k] = st_reg.input_storage_node[k];
            end
            st_next.stage_out[k] = st_reg.output_storage_node[k];
        end
        st_next.xfer_prev = xfer_ph;
        if (!xfer_ph) begin
            st_next.on_cnt = AGE_ZERO;
        end else if (st_reg.on_cnt != ON_SAT) begin
            st_next.on_cnt = st_reg.on_cnt + AGE_ONE;
        end
        if (xfer_ph && hold_ph) begin
            st_next.fault[FAULT_OVERLAP] = 1'b1;
        end
        if (st_reg.xfer_prev && !xfer_ph && st_reg.on_cnt < ON_MIN) begin
            st_next.fault[FAULT_SHORT] = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg           <= '0;
            st_reg.gen_clk_n <= 1'b1;
            st_reg.mode      <= '{default: ST_EMPTY};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register.
    assign gen_clk     = st_reg.gen_clk;
    assign gen_clk_n   = st_reg.gen_clk_n;
    assign bit_out     = st_reg.stage_out;
    assign bit_valid   = st_reg.valid;
    assign phase_fault = st_reg.fault;

    chk_counter_toggle: assert property (@(posedge core_clk) disable iff (reset)
        $fell(cnt_q[0]) |=> (cnt_q[1] != $past(cnt_q[1])))
        else $error("Counter stage did not toggle on falling previous stage.");

    chk_shift_master: assert property (@(posedge core_clk) disable iff (reset)
        $rose(gen_clk) |=> (sr_master[SR_STAGES-1:1] == $past(sr_q[SR_STAGES-2:0])))
        else $error("Shift master did not take previous slave.");

    chk_shift_slave: assert property (@(posedge core_clk) disable iff (reset)
        $fell(gen_clk) |=> (sr_q == $past(sr_master)))
        else $error("Shift slave did not take its master.");

    chk_clock_pair: assert property (@(posedge core_clk) disable iff (reset)
        gen_clk != gen_clk_n)
        else $error("Generated clock pair equal.");

    chk_clock_follow: assert property (@(posedge core_clk) disable iff (reset)
        $rose(square_in) |=> (gen_clk && !gen_clk_n))
        else $error("Generated clock did not follow square wave.");

    chk_xfer_capture: assert property (@(posedge core_clk) disable iff (reset)
        xfer_ph |=> (st_reg.input_storage_node == $past(bit_in)))
        else $error("Transfer phase did not admit data.");

    chk_output_delay: assert property (@(posedge core_clk) disable iff (reset)
        (hold_ph && !xfer_ph) |-> ##2 (bit_out[0] == $past(st_reg.input_storage_node[0], 2)))
        else $error("Stored value late at stage output.");

    chk_latch_hold: assert property (@(posedge core_clk) disable iff (reset)
        (st_reg.mode[LATCHED_IX] == ST_LATCH && !xfer_ph) [*4]
        |-> ($stable(bit_out[LATCHED_IX])
             && bit_valid[LATCHED_IX] == $past(bit_valid[LATCHED_IX])))
        else $error("Latched stage output moved.");

    chk_dynamic_decay: assert property (@(posedge core_clk) disable iff (reset)
        (bit_valid[DYNAMIC_IX] && !xfer_ph && st_reg.age[DYNAMIC_IX] == AGE_LAST)
        |=> !bit_valid[DYNAMIC_IX])
        else $error("Dynamic stage kept data past retention.");

    chk_overlap_flag: assert property (@(posedge core_clk) disable iff (reset)
        (xfer_ph && hold_ph) |=> phase_fault[FAULT_OVERLAP])
        else $error("Phase overlap not flagged.");
endmodule

/* phase_source.sv */
// Behavioural model of the outside phase source for the one-bit stages.
`timescale 1ns/100ps
module phase_source (
    // Clock.
    input  wire logic        core_clk,
    // Command from the bench.
    input  wire logic        go,
    input  wire logic        use_latch,
    input  wire logic        overlap,
    input  wire logic [11:0] xfer_len,
    // Phases and status.
    output logic             xfer_ph,
    output logic             hold_ph,
    output logic             latch_ph,
    output logic             busy
);
    // Hold rests on between frames, as the stages may sit in hold for ever.
    initial begin
        xfer_ph  = 1'b0;
        hold_ph  = 1'b1;
        latch_ph = 1'b0;
        busy     = 1'b0;
    end

    // A command is taken on a rising edge and the phases step on falling edges.
    always begin
        @(posedge core_clk);
        if (go) begin
            @(negedge core_clk);
            busy     = 1'b1;
            latch_ph = 1'b0;
            hold_ph  = overlap;
            @(negedge core_clk);
            xfer_ph = 1'b1;
            repeat (xfer_len) @(negedge core_clk);
            xfer_ph = 1'b0;
            hold_ph = 1'b1;
            repeat (26) @(negedge core_clk);
            latch_ph = use_latch;
            @(negedge core_clk);
            busy = 1'b0;
        end
    end
endmodule

/* clocked_storage_elements_test.sv */
// Self-checking testbench for the clocked storage block.
`timescale 1ns/100ps
module clocked_storage_elements_test;
    import storage_pkg::*;
    logic        core_clk, reset, square_in, ser_in, gen_clk, gen_clk_n;
    logic [3:0]  cnt_q, sr_q, cnt_exp, sr_exp;
    logic        xfer_ph, hold_ph, latch_ph, go, use_latch, overlap, busy;
    logic [11:0] xfer_len;
    logic [1:0]  bit_in, bit_out, bit_valid, phase_fault;
    integer      errors, cmp_count;

    clocked_storage_elements dut_u (.core_clk(core_clk), .reset(reset),
        .square_in(square_in), .ser_in(ser_in), .gen_clk(gen_clk),
        .gen_clk_n(gen_clk_n), .cnt_q(cnt_q), .sr_q(sr_q), .xfer_ph(xfer_ph),
        .hold_ph(hold_ph), .latch_ph(latch_ph), .bit_in(bit_in),
        .bit_out(bit_out), .bit_valid(bit_valid), .phase_fault(phase_fault));

    phase_source src_u (.core_clk(core_clk), .go(go), .use_latch(use_latch),
        .overlap(overlap), .xfer_len(xfer_len), .xfer_ph(xfer_ph),
        .hold_ph(hold_ph), .latch_ph(latch_ph), .busy(busy));

    // The clock toggles every half period of 10 ns.
    always #10 core_clk = ~core_clk;

    // Compares one result of up to four bits and reports a mismatch.
    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Holds reset for 12 cycles and checks every output's reset value.
    task automatic test_reset();
        reset = 1'b1;
        repeat (12) @(negedge core_clk);
        reset   = 1'b0;
        cnt_exp = 4'h0;
        sr_exp  = 4'h0;
        check("gen_clk", 4'h0, {3'h0, gen_clk});
        check("gen_clk_n", 4'h1, {3'h0, gen_clk_n});
        check("cnt_q", 4'h0, cnt_q);
        check("sr_q", 4'h0, sr_q);
        check("bit_out", 4'h0, {2'h0, bit_out});
        check("bit_valid", 4'h0, {2'h0, bit_valid});
        check("phase_fault", 4'h0, {2'h0, phase_fault});
        $display("Done: reset");
    endtask

    // One square wave period with serial data; the count and shift are checked.
    task automatic period(input logic b);
        ser_in    = b;
        square_in = 1'b1;
        @(negedge core_clk);
        check("gen_clk", 4'h1, {3'h0, gen_clk});
        check("gen_clk_n", 4'h0, {3'h0, gen_clk_n});
        repeat (9) @(negedge core_clk);
        square_in = 1'b0;
        @(negedge core_clk);
        check("gen_pair", 4'h1, {3'h0, gen_clk_n & ~gen_clk});
        repeat (9) @(negedge core_clk);
        cnt_exp = cnt_exp + 4'h1;
        sr_exp  = {sr_exp[2:0], b};
        check("cnt_q", cnt_exp, cnt_q);
        check("sr_q", sr_exp, sr_q);
    endtask

    // Seventeen periods carry the counter through its wrap back to one.
    task automatic test_counter();
        repeat (17) period(1'b0);
        check("cnt_wrap", 4'h1, cnt_q);
        $display("Done: counter");
    endtask

    // A mixed serial pattern walks through all four shift stages.
    task automatic test_shift();
        logic [7:0] pat;
        pat = 8'hB4;
        for (int i = 7; i >= 0; i--) period(pat[i]);
        $display("Done: shift");
    endtask

    // Runs one phase frame and waits, bounded, until the source is idle.
    task automatic frame(input logic [1:0] d, input logic lat, input logic ovl,
                         input logic [11:0] len);
        bit_in    = d;
        use_latch = lat;
        overlap   = ovl;
        xfer_len  = len;
        go        = 1'b1;
        @(negedge core_clk);
        go = 1'b0;
        for (int n = 0; n < 3000; n++) begin
            @(posedge core_clk);
            if (!busy) break;
        end
        @(negedge core_clk);
    endtask

    // Data enters on transfer, shows after hold and survives input changes.
    task automatic stage_run(input logic [1:0] d, input logic lat);
        frame(d, lat, 1'b0, 12'h019);
        check("bit_out", {2'h0, d}, {2'h0, bit_out});
        check("bit_valid", 4'h3, {2'h0, bit_valid});
        bit_in = ~d;
        repeat (5) @(negedge core_clk);
        check("bit_hold", {2'h0, d}, {2'h0, bit_out});
    endtask

    // Both stages with and without the latch phase and several data values.
    task automatic test_stages();
        stage_run(2'h1, 1'b1);
        stage_run(2'h2, 1'b0);
        stage_run(2'h3, 1'b1);
        check("phase_fault", 4'h0, {2'h0, phase_fault});
        $display("Done: stages");
    endtask

    // Only the latched stage keeps valid data past the retention span.
    task automatic test_retention();
        stage_run(2'h2, 1'b1);
        repeat (2400) @(negedge core_clk);
        check("valid_early", 4'h3, {2'h0, bit_valid});
        repeat (200) @(negedge core_clk);
        check("valid_late", 4'h1, {2'h0, bit_valid});
        check("bit_kept", 4'h2, {2'h0, bit_out});
        $display("Done: retention");
    endtask

    // A short transfer and an overlap set the sticky faults; reset clears them.
    task automatic test_faults();
        frame(2'h1, 1'b0, 1'b0, 12'h00A);
        check("fault_short", 4'h2, {2'h0, phase_fault});
        frame(2'h1, 1'b0, 1'b1, 12'h019);
        check("fault_both", 4'h3, {2'h0, phase_fault});
        test_reset();
        $display("Done: faults");
    endtask

    // Every input gets a value at time zero, then the tests run in order.
    initial begin
        core_clk  = 1'b0;
        reset     = 1'b1;
        square_in = 1'b0;
        ser_in    = 1'b0;
        bit_in    = 2'h0;
        go        = 1'b0;
        use_latch = 1'b0;
        overlap   = 1'b0;
        xfer_len  = 12'h019;
        errors    = 0;
        cmp_count = 0;
        @(negedge core_clk);
        test_reset();
        test_counter();
        test_shift();
        test_stages();
        test_retention();
        test_faults();
        finish_test();
    end

    // The tests need about 3500 cycles, so a hang is cut after 12000.
    initial begin
        repeat (12000) @(posedge core_clk);
        errors++;
        finish_test();
    end
endmodule
